// file: tdmsto_far_end.sv
`default_nettype none
module tdmsto_far_end
  import tdmsto_pkg::*;
(
  input wire logic activeHigh,
  input wire logic doubleWidth,
  output logic masterClockIn,
  output logic masterFramePulseIn
);
  timeunit 1ns;
  timeprecision 1ns;
  int edgeCount = 1000;
  logic pulseOn = 1'b0;
  // The framer's bit clock runs free and the frame count starts at 1000, so the first pulse comes 24 rising edges in, soon after reset.
  initial begin
    masterClockIn = 1'b1;
    forever #80 masterClockIn = ~masterClockIn;
  end
  // The pulse spans one falling edge, or two when double width is asked for.
  always @(posedge masterClockIn) begin
    edgeCount <= (edgeCount + 1) % FRAME_EDGES;
    pulseOn <= (edgeCount == FRAME_EDGES - 1) || (doubleWidth && edgeCount == 0);
  end
  assign masterFramePulseIn = activeHigh ? pulseOn : ~pulseOn;
endmodule
`default_nettype wire

// file: tdmsto_pkg.sv
`default_nettype none
package tdmsto_pkg;
  localparam int LOCAL_STREAMS = 16;
  localparam int BP_STREAMS = 32;
  localparam int ALL_STREAMS = LOCAL_STREAMS + BP_STREAMS;
  localparam int LOCAL_FAST_STREAMS = 8;
  localparam int BP_FAST_STREAMS = 16;
  localparam int FRAME_EDGES = 1024;
  localparam int BITS_PER_CHANNEL = 8;
  localparam int CHAN_W = 9;
  localparam int BITD_W = 5;
  localparam int ADV_W = 2;
  localparam int EFF_W = 15;
  localparam real SYSTEM_CLOCK_MHZ = 131.072;
  localparam int ADV_STEP_SLOW = 2;
  localparam int ADV_STEP_FAST = 1;
  localparam logic [3:0] GRP_CTRL = 4'h0;
  localparam logic [3:0] GRP_LCHAN = 4'h1;
  localparam logic [3:0] GRP_LBIT = 4'h2;
  localparam logic [3:0] GRP_LADV = 4'h3;
  localparam logic [3:0] GRP_BCHAN = 4'h4;
  localparam logic [3:0] GRP_BBIT = 4'h5;
  localparam logic [3:0] GRP_BADV = 4'h6;
  localparam logic [3:0] GRP_LEFF = 4'h7;
  localparam logic [3:0] GRP_BEFF = 4'h8;
  localparam logic [5:0] IDX_CTRL = 6'h00;
  localparam logic [5:0] IDX_STATUS = 6'h01;
  localparam int EFF_ADV_POS = 16;
  localparam logic [2:0] DISC_MODE_LOW = 3'h0;
  localparam logic [2:0] DISC_MODE_FULL = 3'h7;
  localparam logic [CHAN_W-1:0] CHAN_RESET = 9'h000;
  localparam logic [BITD_W-1:0] BITD_RESET = 5'h00;
  localparam logic [ADV_W-1:0] ADV_RESET = 2'h0;

  typedef struct packed {
    logic mode32Backplane;
    logic mode32Local;
    logic samplingModeSel;
    logic [2:0] boundaryDiscriminatorMode;
    logic boundaryDiscriminatorEnable;
    logic outputClockEdgeSel;
    logic inputClockEdgeSel;
    logic framePulseWidthSel;
  } tdmsto_ctrl_t;
  localparam tdmsto_ctrl_t CTRL_RESET = '0;

  typedef struct packed {
    logic [1:0] outFrame;
    logic [1:0] inFrame;
    logic discActive;
    logic styleHigh;
  } tdmsto_status_t;

  typedef struct packed {
    logic [11:0] address;
    logic read;
    logic write;
    logic [31:0] writeData;
    logic [3:0] byteEnable;
  } tdmsto_avs_req_t;

  typedef enum logic [2:0] {K_NONE, K_CTRL, K_STATUS, K_CHAN, K_BIT, K_ADV, K_EFF} tdmsto_kind_t;
  typedef struct packed {
    tdmsto_kind_t kind;
    logic [5:0] slot;
  } tdmsto_sel_t;
endpackage
`default_nettype wire

// file: tdmsto_timing_offset.sv
// How it works
// - Bytes of frame N leave in frame N+2.
// - One master pulse yields 8M and 16M pulses.
// - Width bit doubles input and output pulses.
// - Polarity bits pick input and output edges.
// - Discriminator runs only when enabled; reset disables.
// - Mode 000 low jitter, 111 both, others reserved.
// - Mode field ignored while discriminator disabled.
// - Every input stream has its channel delay.
// - Channel delays reset to zero.
// - Channel plus bit delay gives quarter-bit placement.
// - Sampling bit low: five-bit quarter-step delay.
// - Sampling bit high: low two bits pick point.
// - Sampling bit high: upper three bits whole bits.
// - Every output stream has its advancement register.
// - Slow streams advance 0, 2, 4, 6 cycles.
// - 32 Mbps streams advance 0, 1, 2, 3 cycles.
// - Pulse style detected; outputs follow that style.
`default_nettype none
module tdmsto_timing_offset
  import tdmsto_pkg::*;
(
  input wire logic sys_clk,
  input wire logic reset,
  input wire tdmsto_avs_req_t avsReq,
  output logic [31:0] avsReadData,
  output logic avsWaitRequest,
  input wire logic masterClockIn,
  input wire logic masterFramePulseIn,
  output logic framePulseOut8m,
  output logic framePulseOut16m,
  output logic frameBoundary
);
  typedef enum logic {BUS_IDLE, BUS_DONE} tdmsto_bus_t;

  function automatic tdmsto_sel_t decode(input logic [3:0] grp, input logic [5:0] idx);
    tdmsto_sel_t s;
    logic isLocal;
    s = '{kind: K_NONE, slot: 6'h00};
    isLocal = (grp == GRP_LCHAN) || (grp == GRP_LBIT) || (grp == GRP_LADV) || (grp == GRP_LEFF);
    if (grp == GRP_CTRL) begin
      if (idx == IDX_CTRL) s.kind = K_CTRL;
      if (idx == IDX_STATUS) s.kind = K_STATUS;
    end else if (isLocal ? (idx < 6'(LOCAL_STREAMS)) : (idx < 6'(BP_STREAMS))) begin
      s.slot = isLocal ? idx : 6'(idx + 6'(LOCAL_STREAMS));
      unique case (grp)
        GRP_LCHAN, GRP_BCHAN: s.kind = K_CHAN;
        GRP_LBIT, GRP_BBIT: s.kind = K_BIT;
        GRP_LADV, GRP_BADV: s.kind = K_ADV;
        GRP_LEFF, GRP_BEFF: s.kind = K_EFF;
        default: s.kind = K_NONE;
      endcase
    end
    return s;
  endfunction

  function automatic logic [31:0] laneMerge(input logic [31:0] oldV, input logic [31:0] newV,
                                            input logic [3:0] be);
    logic [31:0] m;
    m = oldV;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) m[8*i +: 8] = newV[8*i +: 8];
    end
    return m;
  endfunction

  // Input placement in quarter bits from the frame boundary.
  function automatic logic [EFF_W-1:0] inOffset(input logic [CHAN_W-1:0] chan,
                                                input logic [BITD_W-1:0] bits,
                                                input logic smpl);
    logic [EFF_W-1:0] base;
    logic [2:0] point;
    base = EFF_W'({chan, 5'h00});
    unique case (bits[1:0])
      2'h0: point = 3'h3;
      2'h1: point = 3'h4;
      2'h2: point = 3'h1;
      2'h3: point = 3'h2;
    endcase
    if (smpl) return EFF_W'(base + EFF_W'({bits[4:2], 2'h0}) + EFF_W'(point));
    return EFF_W'(base + EFF_W'(bits));
  endfunction

  function automatic logic [2:0] advCycles(input logic [ADV_W-1:0] code, input logic fast);
    return fast ? 3'(code * ADV_STEP_FAST) : 3'(code * ADV_STEP_SLOW);
  endfunction

  tdmsto_ctrl_t ctrl;
  tdmsto_status_t status;
  tdmsto_bus_t busState;
  tdmsto_sel_t sel;
  logic [CHAN_W-1:0] chanDelay [ALL_STREAMS];
  logic [BITD_W-1:0] bitDelay [ALL_STREAMS];
  logic [ADV_W-1:0] advCode [ALL_STREAMS];
  logic [31:0] readValue;
  logic fastSlot;
  logic clkMeta, clkSync, clkPrev, fpMeta, fpSync;
  logic activeEdge, pulseActive, pulseSeen, expected, nearExpected, frameTick;
  logic [7:0] periodCnt, period;
  logic [2:0] runLen;
  logic lastLevel, styleHigh;
  logic [1:0] pulseCnt;
  logic edgePulsePrev;
  logic [9:0] edgeCnt;
  logic [1:0] inFrame, outFrame;
  logic [9:0] outTimer, pwCycles;
  logic fp8Active, fp16Active;

  assign sel = decode(avsReq.address[11:8], avsReq.address[7:2]);
  assign fastSlot = (sel.slot < 6'(LOCAL_STREAMS))
      ? (ctrl.mode32Local && sel.slot < 6'(LOCAL_FAST_STREAMS))
      : (ctrl.mode32Backplane && sel.slot < 6'(LOCAL_STREAMS + BP_FAST_STREAMS));
  assign status = '{outFrame: outFrame, inFrame: inFrame,
                    discActive: ctrl.boundaryDiscriminatorEnable, styleHigh: styleHigh};

  always_comb begin
    readValue = 32'h0000_0000;
    unique case (sel.kind)
      K_CTRL: readValue = 32'(ctrl);
      K_STATUS: readValue = 32'(status);
      K_CHAN: readValue = 32'(chanDelay[sel.slot]);
      K_BIT: readValue = 32'(bitDelay[sel.slot]);
      K_ADV: readValue = 32'(advCode[sel.slot]);
      K_EFF: begin
        readValue[EFF_W-1:0] = inOffset(chanDelay[sel.slot], bitDelay[sel.slot],
                                        ctrl.samplingModeSel);
        readValue[EFF_ADV_POS +: 3] = advCycles(advCode[sel.slot], fastSlot);
      end
      default: readValue = 32'h0000_0000;
    endcase
  end

  // Every access gets exactly one wait cycle, so reads see settled array data.
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      busState <= BUS_IDLE;
      avsWaitRequest <= 1'b1;
      avsReadData <= 32'h0000_0000;
    end else begin
      unique case (busState)
        BUS_IDLE: begin
          if (avsReq.read || avsReq.write) begin
            busState <= BUS_DONE;
            avsWaitRequest <= 1'b0;
            avsReadData <= avsReq.read ? readValue : 32'h0000_0000;
          end
        end
        BUS_DONE: begin
          busState <= BUS_IDLE;
          avsWaitRequest <= 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      ctrl <= CTRL_RESET;
      for (int i = 0; i < ALL_STREAMS; i++) begin
        chanDelay[i] <= CHAN_RESET;
        bitDelay[i] <= BITD_RESET;
        advCode[i] <= ADV_RESET;
      end
    end else if (busState == BUS_DONE && avsReq.write) begin
      unique case (sel.kind)
        K_CTRL: ctrl <= tdmsto_ctrl_t'(10'(laneMerge(32'(ctrl), avsReq.writeData,
                                                     avsReq.byteEnable)));
        K_CHAN: chanDelay[sel.slot] <= CHAN_W'(laneMerge(32'(chanDelay[sel.slot]),
                                               avsReq.writeData, avsReq.byteEnable));
        K_BIT: bitDelay[sel.slot] <= BITD_W'(laneMerge(32'(bitDelay[sel.slot]),
                                             avsReq.writeData, avsReq.byteEnable));
        K_ADV: advCode[sel.slot] <= ADV_W'(laneMerge(32'(advCode[sel.slot]),
                                           avsReq.writeData, avsReq.byteEnable));
        default: ;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      clkMeta <= 1'b0;
      clkSync <= 1'b0;
      clkPrev <= 1'b0;
      fpMeta <= 1'b1;
      fpSync <= 1'b1;
    end else begin
      clkMeta <= masterClockIn;
      clkSync <= clkMeta;
      clkPrev <= clkSync;
      fpMeta <= masterFramePulseIn;
      fpSync <= fpMeta;
    end
  end

  assign activeEdge = ctrl.inputClockEdgeSel ? (clkSync && !clkPrev) : (!clkSync && clkPrev);

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      periodCnt <= 8'h00;
      period <= 8'h02;
    end else if (activeEdge) begin
      periodCnt <= 8'h00;
      period <= (periodCnt == 8'hFF) ? 8'hFF : 8'(periodCnt + 8'h01);
    end else if (periodCnt != 8'hFF) begin
      periodCnt <= 8'(periodCnt + 8'h01);
    end
  end

  // The pulse is the level that lasts at most two samples; idle lasts a frame.
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      runLen <= 3'h0;
      lastLevel <= 1'b1;
      styleHigh <= 1'b0;
    end else if (activeEdge) begin
      if (fpSync == lastLevel) begin
        if (runLen != 3'h7) runLen <= 3'(runLen + 3'h1);
      end else begin
        if (runLen != 3'h0 && runLen <= 3'h2) styleHigh <= lastLevel;
        runLen <= 3'h1;
        lastLevel <= fpSync;
      end
    end
  end

  assign pulseActive = (fpSync == styleHigh);
  always_ff @(posedge sys_clk) begin
    if (reset) pulseCnt <= 2'h0;
    else if (activeEdge) pulseCnt <= pulseActive ? ((pulseCnt == 2'h3) ? 2'h3 : 2'(pulseCnt + 2'h1)) : 2'h0;
  end
  // Keeps the pulse level seen at the previous active edge, so a double pulse can be checked.
  always_ff @(posedge sys_clk) begin
    if (reset) edgePulsePrev <= 1'b0;
    else if (activeEdge) edgePulsePrev <= pulseActive;
  end
  assign pulseSeen = activeEdge && pulseActive &&
                     (pulseCnt == (ctrl.framePulseWidthSel ? 2'h1 : 2'h0));

  assign expected = (edgeCnt == 10'(FRAME_EDGES - 1));
  assign nearExpected = (edgeCnt >= 10'(FRAME_EDGES - 2)) || (edgeCnt == 10'h000);

  // Mode 111 flywheels through small boundary wander; 000 and reserved codes retrack at once.
  always_comb begin
    if (!activeEdge) frameTick = 1'b0;
    else if (!ctrl.boundaryDiscriminatorEnable) frameTick = pulseSeen;
    else if (ctrl.boundaryDiscriminatorMode == DISC_MODE_FULL)
      frameTick = expected || (pulseSeen && !nearExpected);
    else frameTick = pulseSeen || expected;
  end

  always_ff @(posedge sys_clk) begin
    if (reset) edgeCnt <= 10'h000;
    else if (activeEdge) edgeCnt <= frameTick ? 10'h000 : 10'(edgeCnt + 10'h001);
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      inFrame <= 2'h0;
      outFrame <= 2'h2;
      frameBoundary <= 1'b0;
    end else begin
      frameBoundary <= frameTick;
      if (frameTick) begin
        inFrame <= 2'(inFrame + 2'h1);
        outFrame <= 2'(inFrame - 2'h1);
      end
    end
  end

  assign pwCycles = ctrl.framePulseWidthSel ? {1'b0, period, 1'b0} : {2'b00, period};
  assign fp8Active = (outTimer != 10'h000) && (outTimer <= pwCycles);
  assign fp16Active = fp8Active && (outTimer > (pwCycles >> 1));

  always_ff @(posedge sys_clk) begin
    if (reset) outTimer <= 10'h000;
    else if (frameTick)
      outTimer <= 10'(pwCycles + (ctrl.outputClockEdgeSel ? 10'(period >> 1) : 10'h000));
    else if (outTimer != 10'h000) outTimer <= 10'(outTimer - 10'h001);
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      framePulseOut8m <= 1'b1;
      framePulseOut16m <= 1'b1;
    end else begin
      framePulseOut8m <= fp8Active ? styleHigh : !styleHigh;
      framePulseOut16m <= fp16Active ? styleHigh : !styleHigh;
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);

  disc_reset_off_a: assert property ($fell(reset) |-> !ctrl.boundaryDiscriminatorEnable)
    else $error("discriminator enabled after reset");
  chan_reset_zero_a: assert property ($fell(reset) |-> chanDelay[0] == CHAN_RESET)
    else $error("channel delay not zero after reset");
  frame_latency_a: assert property (frameTick |=> outFrame == 2'(inFrame - 2'h2))
    else $error("output frame not two behind input frame");
  mode_ignored_a: assert property (!ctrl.boundaryDiscriminatorEnable && activeEdge |-> frameTick == pulseSeen)
    else $error("mode used while discriminator off");
  reserved_mode_a: assert property (ctrl.boundaryDiscriminatorEnable && ctrl.boundaryDiscriminatorMode != DISC_MODE_FULL && pulseSeen |-> frameTick)
    else $error("low jitter mode missed a pulse");
  point_map_a: assert property (ctrl.samplingModeSel && bitDelay[0] == 5'h00 |-> inOffset(chanDelay[0], bitDelay[0], 1'b1) == EFF_W'({chanDelay[0], 5'h03}))
    else $error("sampling point code 00 not three quarters");
  pulse_out_a: assert property (frameTick ##1 !ctrl.outputClockEdgeSel [*1] |-> ##1 framePulseOut8m == styleHigh)
    else $error("output pulse not started after boundary");
  bus_answer_a: assert property ((avsReq.read || avsReq.write) && busState == BUS_IDLE |=> !avsWaitRequest ##1 avsWaitRequest)
    else $error("bus answer not one cycle");
  width_dbl_a: assert property (pulseSeen && ctrl.framePulseWidthSel |-> edgePulsePrev)
    else $error("double width pulse taken on its first edge");

  frame_tick_c: cover property (frameTick ##1 frameBoundary);
  full_mode_c: cover property (ctrl.boundaryDiscriminatorEnable && ctrl.boundaryDiscriminatorMode == DISC_MODE_FULL && expected && activeEdge);
  style_high_c: cover property ($rose(styleHigh));
  write_ctrl_c: cover property (busState == BUS_DONE && avsReq.write && sel.kind == K_CTRL);
endmodule
`default_nettype wire

// file: tdmsto_timing_offset_test.sv
`default_nettype none
module tdmsto_timing_offset_test
  import tdmsto_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int CYC = 16;
  logic sys_clk = 1'b0;
  logic reset = 1'b1;
  tdmsto_avs_req_t avsReq = '0;
  logic [31:0] avsReadData;
  logic avsWaitRequest;
  logic masterClockIn;
  logic masterFramePulseIn;
  logic framePulseOut8m;
  logic framePulseOut16m;
  logic frameBoundary;
  logic activeHigh = 1'b0;
  logic doubleWidth = 1'b0;
  int miscompares = 0;
  int numChecks = 0;
  int seed = 98;
  int n;
  logic [31:0] d;
  logic [31:0] r;
  logic side, m32, smpl, fast;
  logic [8:0] chan;
  logic [4:0] fld;
  logic [1:0] code;
  logic [5:0] s;
  tdmsto_status_t st;

  tdmsto_timing_offset i_dut (.sys_clk(sys_clk), .reset(reset), .avsReq(avsReq),
    .avsReadData(avsReadData), .avsWaitRequest(avsWaitRequest),
    .masterClockIn(masterClockIn), .masterFramePulseIn(masterFramePulseIn),
    .framePulseOut8m(framePulseOut8m), .framePulseOut16m(framePulseOut16m),
    .frameBoundary(frameBoundary));
  tdmsto_far_end i_far (.activeHigh(activeHigh), .doubleWidth(doubleWidth),
    .masterClockIn(masterClockIn), .masterFramePulseIn(masterFramePulseIn));

  initial begin
    forever #5 sys_clk = ~sys_clk;
  end

  function automatic logic [14:0] effOffset(logic [8:0] c, logic [4:0] f, logic sm);
    logic [2:0] pt;
    pt = (f[1:0] == 2'h0) ? 3'h3 : (f[1:0] == 2'h1) ? 3'h4 : (f[1:0] == 2'h2) ? 3'h1 : 3'h2;
    return 15'(c) * 15'h20 + (sm ? 15'(f[4:2]) * 15'h4 + 15'(pt) : 15'(f));
  endfunction

  function automatic logic [2:0] advCycles(logic [1:0] c, logic f);
    return f ? {1'b0, c} : {c, 1'b0};
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    numChecks++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic chkNear(input int got, input int exp, input string what);
    numChecks++;
    if (got < exp - 1 || got > exp + 1) begin
      miscompares++;
      $display("CHECK FAILED at %0t: %s got %0d expected %0d", $time, what, got, exp);
    end
  endtask

  // The request is held until waitrequest is seen low, for at most 50 cycles.
  task automatic bus(input logic w, input logic [3:0] g, input logic [5:0] idx,
      input logic [31:0] wd, output logic [31:0] rdat);
    int k;
    k = 0;
    avsReq <= '{address: {g, idx, 2'h0}, read: ~w, write: w, writeData: wd, byteEnable: 4'hF};
    do begin
      @(posedge sys_clk);
      k++;
    end while (avsWaitRequest !== 1'b0 && k < 50);
    rdat = avsReadData;
    chk(32'(k < 50), 32'h1, "bus answer");
    avsReq.read <= 1'b0;
    avsReq.write <= 1'b0;
    @(posedge sys_clk);
  endtask

  task automatic wr(input logic [3:0] g, input logic [5:0] idx, input logic [31:0] wd);
    logic [31:0] dummy;
    bus(1'b1, g, idx, wd, dummy);
  endtask

  task automatic rd(input logic [3:0] g, input logic [5:0] idx, output logic [31:0] rdat);
    bus(1'b0, g, idx, 32'h0, rdat);
  endtask

  task automatic waitBnd(output int cnt);
    cnt = 0;
    do begin
      @(posedge sys_clk);
      cnt++;
    end while (frameBoundary !== 1'b1 && cnt < 20000);
    chk(32'(cnt < 20000), 32'h1, "boundary seen");
  endtask

  task automatic pulseWidths(input logic lvl, input int w);
    int n8, n16;
    n8 = 0;
    n16 = 0;
    repeat (80) begin
      @(posedge sys_clk);
      n8 += int'(framePulseOut8m === lvl);
      n16 += int'(framePulseOut16m === lvl);
    end
    chkNear(n8, w, "8m pulse width");
    chkNear(n16, w / 2, "16m pulse width");
  endtask

  task automatic finishTest();
    $display("checks %0d miscompares %0d", numChecks, miscompares);
    if (miscompares == 0 && numChecks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  initial begin
    repeat (100000) @(posedge sys_clk);
    miscompares++;
    finishTest();
  end

  initial begin
    repeat (20) @(posedge sys_clk);
    reset <= 1'b0;
    @(posedge sys_clk);
    rd(GRP_CTRL, IDX_CTRL, d);
    chk(d, 32'h0, "ctrl reset");
    for (int k = 1; k < 7; k++) begin
      rd(4'(k), 6'h0F, d);
      chk(d, 32'h0, "offset reset");
    end
    $display("test reset_values done");
    // The first four passes force each point and advance code; the rest are random.
    for (int i = 0; i < 12; i++) begin
      r = $random(seed);
      side = i[0];
      chan = r[8:0];
      fld = r[13:9];
      code = r[15:14];
      m32 = r[16];
      smpl = r[17];
      s = side ? {1'b0, r[22:18]} : {2'h0, r[21:18]};
      if (i < 4) begin
        smpl = 1'b1;
        fld = {3'h7, i[1:0]};
        code = i[1:0];
      end
      fast = m32 && (s < (side ? BP_FAST_STREAMS : LOCAL_FAST_STREAMS));
      wr(GRP_CTRL, IDX_CTRL, {22'h0, m32, m32, smpl, 7'h00});
      wr(side ? GRP_BCHAN : GRP_LCHAN, s, 32'(chan));
      wr(side ? GRP_BBIT : GRP_LBIT, s, 32'(fld));
      wr(side ? GRP_BADV : GRP_LADV, s, 32'(code));
      rd(side ? GRP_BCHAN : GRP_LCHAN, s, d);
      chk(d, 32'(chan), "chan delay");
      rd(side ? GRP_BBIT : GRP_LBIT, s, d);
      chk(d, 32'(fld), "bit delay");
      rd(side ? GRP_BEFF : GRP_LEFF, s, d);
      chk(32'(d[14:0]), 32'(effOffset(chan, fld, smpl)), "offset");
      chk(32'(d[18:16]), 32'(advCycles(code, fast)), "advance");
    end
    wr(GRP_LCHAN, 6'h10, 32'h1FF);
    rd(GRP_LCHAN, 6'h10, d);
    chk(d, 32'h0, "unmapped");
    $display("test offsets done");
    for (int m = 0; m < 8; m++) begin
      wr(GRP_CTRL, IDX_CTRL, {25'h0, 3'(m), 4'h8});
      rd(GRP_CTRL, IDX_STATUS, d);
      chk(32'(d[1]), 32'h1, "disc on");
    end
    wr(GRP_CTRL, IDX_CTRL, 32'h70);
    rd(GRP_CTRL, IDX_STATUS, d);
    chk(32'(d[1]), 32'h0, "disc off");
    $display("test discriminator done");
    wr(GRP_CTRL, IDX_CTRL, 32'h78);
    waitBnd(n);
    pulseWidths(1'b0, CYC);
    waitBnd(n);
    chkNear(n + 80, FRAME_EDGES * CYC, "frame period");
    rd(GRP_CTRL, IDX_STATUS, d);
    st = tdmsto_status_t'(d[5:0]);
    chk(32'(st.outFrame), 32'(2'(st.inFrame - 2'h2)), "frame lag");
    activeHigh <= 1'b1;
    doubleWidth <= 1'b1;
    wr(GRP_CTRL, IDX_CTRL, 32'h1);
    // The first pulse after a style flip only teaches the detector, so 20000 cycles pass, a little over one 16384-cycle frame.
    repeat (20000) @(posedge sys_clk);
    waitBnd(n);
    waitBnd(n);
    pulseWidths(1'b1, 2 * CYC);
    rd(GRP_CTRL, IDX_STATUS, d);
    chk(32'(d[0]), 32'h1, "style high");
    $display("test frame_pulses done");
    finishTest();
  end
endmodule
`default_nettype wire
